//--- bench/emb_bus_sva.sv
// ----------------------------------------
// Bus pin checks
// ----------------------------------------
module emb_chk (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic wait_enable_in,
	input wire logic [7:0] p0_oe_n_out,
	input wire logic p2_strong_out,
	input wire logic address_latch_strobe_out,
	input wire logic program_store_strobe_n_out,
	input wire logic write_strobe_n_out,
	input wire logic read_strobe_n_out,
	input wire logic p40_oe_n_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_rd6; !read_strobe_n_out [*6]; endsequence
	sequence s_wr6; !write_strobe_n_out [*6]; endsequence
	property p_rd_rel; !read_strobe_n_out |-> &p0_oe_n_out; endproperty
	a_rd_rel: assert property (p_rd_rel) else $error("p0 driven");
	property p_wr_drv; !write_strobe_n_out |-> p0_oe_n_out == 8'h00;
	endproperty
	a_wr_drv: assert property (p_wr_drv) else $error("p0 idle");
	property p_ale_drv; address_latch_strobe_out |->
		!p0_oe_n_out && p2_strong_out;
	endproperty
	a_ale_drv: assert property (p_ale_drv) else $error("addr weak");
	property p_ale_len; $rose(address_latch_strobe_out) |=>
		address_latch_strobe_out ##1 !address_latch_strobe_out; endproperty
	a_ale_len: assert property (p_ale_len) else $error("latch len");
	property p_rd_len; $fell(read_strobe_n_out) |-> s_rd6; endproperty
	a_rd_len: assert property (p_rd_len) else $error("read short");
	property p_wr_len; $fell(write_strobe_n_out) |-> s_wr6; endproperty
	a_wr_len: assert property (p_wr_len) else $error("write short");
	property p_ps_len; $fell(program_store_strobe_n_out) |->
		!program_store_strobe_n_out [*2] ##1 program_store_strobe_n_out;
	endproperty
	a_ps_len: assert property (p_ps_len) else $error("fetch len");
	property p_excl; !read_strobe_n_out |-> write_strobe_n_out &&
		program_store_strobe_n_out && p2_strong_out; endproperty
	a_excl: assert property (p_excl) else $error("strobe clash");
	property p_wait; wait_enable_in |-> p40_oe_n_out; endproperty
	a_wait: assert property (p_wait) else $error("wait pin driven");
endmodule : emb_chk

//--- bench/emb_mem.sv
// ----------------------------------------
// External memory model
// ----------------------------------------
module emb_mem (
	input wire logic clk_in,
	input wire logic ale_in,
	input wire logic [7:0] p0_in,
	input wire logic [7:0] p2_in,
	input wire logic program_store_strobe_n_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic [3:0] slow_in,
	output logic [7:0] d_out,
	output logic d_en_out,
	output logic wait_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:65535];
	logic [15:0] a;
	int n;
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = i[7:0] ^ i[15:8];
		end
	end
	always @(posedge clk_in) begin
		if (ale_in) begin
			a <= {p2_in, p0_in};
		end
		if (!wr_n_in) begin
			mem[a] <= p0_in;
		end
		n <= (rd_n_in && wr_n_in) ? 0 : n + 1;
	end
	assign d_en_out = !rd_n_in || !program_store_strobe_n_in;
	assign d_out = mem[a];
	assign wait_out = !(rd_n_in && wr_n_in) && n < 4 * slow_in + 2;
endmodule : emb_mem

//--- bench/testbench.sv
// ----------------------------------------
// Testbench
// ----------------------------------------
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk_in, sys_rst_in, onchip_xram_enable_in, wait_enable_in;
	logic external_fetch_force_in, req_valid_in, req_ready_out, rsp_valid_out;
	logic rsp_ready_in, rsp_internal_out, p2_strong_out, address_latch_strobe_out;
	logic program_store_strobe_n_out, write_strobe_n_out, read_strobe_n_out;
	logic p40_in, p40_out, p40_oe_n_out, p40_gpio_in, den, wt;
	logic [3:0] stretch_mc_in, slow;
	emb_pkg::emb_kind_t req_kind_in;
	logic [15:0] req_addr_in;
	logic [7:0] req_wdata_in, rsp_data_out, p0_in, p0_out, p0_oe_n_out;
	logic [7:0] p0_gpio_in, p2_out, dout, last;
	int failures, cmp_count;
	emb_bus DUT (.*);
	emb_mem u_mem (.clk_in(sys_clk_in), .ale_in(address_latch_strobe_out),
		.p0_in(p0_in), .p2_in(p2_out), .program_store_strobe_n_in(program_store_strobe_n_out),
		.rd_n_in(read_strobe_n_out), .wr_n_in(write_strobe_n_out),
		.slow_in(slow), .d_out(dout), .d_en_out(den), .wait_out(wt));
	assign p0_in = (~p0_oe_n_out & p0_out) |
		(p0_oe_n_out & ({8{den}} & dout | {8{!den}} & ~last));
	assign p40_in = p40_oe_n_out ? wt : p40_out;
	always @(posedge sys_clk_in) last <= p0_in;
	initial begin
		sys_clk_in = 0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task send(input logic [1:0] k, input logic [15:0] ad, input logic [7:0] wd);
		req_kind_in <= emb_pkg::emb_kind_t'(k);
		req_addr_in <= ad;
		req_wdata_in <= wd;
		req_valid_in <= 1'b1;
		do @(posedge sys_clk_in); while (req_ready_out !== 1'b1);
		req_valid_in <= 1'b0;
	endtask : send
	task take(input logic [7:0] ed, input logic ei, input int el);
		int n;
		n = 0;
		rsp_ready_in <= 1'b1;
		@(posedge sys_clk_in);
		while (rsp_valid_out !== 1'b1 && n < 300) begin
			@(posedge sys_clk_in);
			n++;
		end
		if (n >= 300) begin
			failures++;
			$display("ERROR %0t no answer", $time);
		end
		if (el >= 0) chk(rsp_data_out, ed);
		chk({7'h0, rsp_internal_out}, {7'h0, ei});
		if (el > 0) chk(8'(n), 8'(el));
		rsp_ready_in <= 1'b0;
		@(posedge sys_clk_in);
	endtask : take
	task xfer(input logic [1:0] k, input logic [15:0] ad, input logic [7:0] wd,
		input logic [7:0] ed, input logic ei, input int el);
		send(k, ad, wd);
		take(ed, ei, el);
	endtask : xfer
	task t_stretch;
		int e;
		for (int s = 0; s < 16; s++) begin
			e = s < 2 ? 2 : s > 9 ? 9 : s;
			stretch_mc_in <= 4'(s);
			xfer(2, 16'h1234, 8'h00, 8'h26, 0, 2 + 4 * e);
		end
		stretch_mc_in <= 4'h2;
	endtask : t_stretch
	task t_data;
		xfer(2, 16'h0010, 8'h00, 8'h10, 0, 10);
		onchip_xram_enable_in <= 1'b1;
		xfer(3, 16'h0400, 8'h5a, 8'h5a, 0, 10);
		xfer(2, 16'h0400, 8'h00, 8'h5a, 0, 10);
		xfer(3, 16'h03ff, 8'ha5, 8'ha5, 1, 0);
		xfer(2, 16'h03ff, 8'h00, 8'ha5, 1, 0);
		onchip_xram_enable_in <= 1'b0;
		xfer(2, 16'h03ff, 8'h00, 8'hfc, 0, 10);
	endtask : t_data
	task t_fetch;
		external_fetch_force_in <= 1'b1;
		xfer(0, 16'h7fff, 8'h00, 8'h00, 1, -1);
		xfer(1, 16'h8000, 8'h00, 8'h80, 0, 6);
		external_fetch_force_in <= 1'b0;
		xfer(0, 16'h0100, 8'h00, 8'h01, 0, 6);
		xfer(1, 16'h0001, 8'h00, 8'h01, 0, 6);
	endtask : t_fetch
	task t_wait;
		wait_enable_in <= 1'b1;
		slow <= 4'h2;
		xfer(2, 16'h2233, 8'h00, 8'h11, 0, 18);
		slow <= 4'h0;
		wait_enable_in <= 1'b0;
	endtask : t_wait
	task t_buf;
		p0_gpio_in <= 8'h5a;
		@(posedge sys_clk_in);
		chk(p0_oe_n_out, 8'h5a);
		p0_gpio_in <= 8'h00;
		send(2, 16'h1234, 8'h00);
		@(posedge sys_clk_in);
		send(2, 16'h0102, 8'h00);
		repeat (40) @(posedge sys_clk_in);
		chk({7'h0, req_ready_out}, 8'h00);
		take(8'h26, 0, 0);
		take(8'h03, 0, 0);
		chk({7'h0, req_ready_out}, 8'h01);
	endtask : t_buf
	task conclude;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	initial begin
		{failures, cmp_count} = 0;
		{sys_rst_in, slow, stretch_mc_in} = 9'h102;
		{onchip_xram_enable_in, wait_enable_in, external_fetch_force_in} = 0;
		{req_valid_in, rsp_ready_in, req_addr_in, req_wdata_in} = 0;
		{p0_gpio_in, p40_gpio_in, last} = 17'h100;
		req_kind_in = emb_pkg::EMB_FETCH;
		repeat (16) @(posedge sys_clk_in);
		sys_rst_in <= 1'b0;
		t_stretch();
		t_data();
		t_fetch();
		t_wait();
		t_buf();
		conclude();
	end
	initial begin
		#400000;
		failures++;
		conclude();
	end
endmodule : testbench
bind emb_bus emb_chk u_chk (
	.sys_clk_in(sys_clk_in),
	.sys_rst_in(sys_rst_in),
	.wait_enable_in(wait_enable_in),
	.p0_oe_n_out(p0_oe_n_out),
	.p2_strong_out(p2_strong_out),
	.address_latch_strobe_out(address_latch_strobe_out),
	.program_store_strobe_n_out(program_store_strobe_n_out),
	.write_strobe_n_out(write_strobe_n_out),
	.read_strobe_n_out(read_strobe_n_out),
	.p40_oe_n_out(p40_oe_n_out)
);

//--- common/emb_pkg.sv
package emb_pkg;
	// ----------------------------------------
	// Bus timing
	// ----------------------------------------
	localparam int unsigned CLK_PER_MC = 4;
	localparam logic [3:0] STRETCH_MIN = 4'h2;
	localparam logic [3:0] STRETCH_MAX = 4'h9;
	localparam logic [3:0] STRETCH_RST = 4'h2;
	// ----------------------------------------
	// Address map
	// ----------------------------------------
	localparam logic [15:0] XRAM_TOP = 16'h03ff;
	localparam logic [15:0] ROM_TOP = 16'h7fff;
	localparam int unsigned XRAM_DEPTH = 1024;
	// ----------------------------------------
	// Access kinds and bus states
	// ----------------------------------------
	typedef enum logic [1:0] {
		EMB_FETCH,
		EMB_TABLE,
		EMB_DREAD,
		EMB_DWRITE
	} emb_kind_t;
	typedef enum logic [2:0] {
		EMB_IDLE,
		EMB_ADDR,
		EMB_STROBE,
		EMB_DONE
	} emb_state_t;
endpackage : emb_pkg

//--- logic/emb_bus.sv
// Functional notes
// - Port 0 drives address/data actively during external accesses, else open-drain.
// - Port 2 drives upper address actively while Port 0 is the bus.
// - Software sets data-move duration from two to nine machine cycles.
// - On-chip 1 KB data SRAM at 0000H-03FFH, data moves only, enable-controlled.
// - Write strobe on P3.6, read strobe on P3.7 for external data.
// - P4.0 wait input; input only once enabled; far side may hold it.
// - One machine cycle is four clocks.
// - Program store strobe for external fetch and table reads, never internal.
// - Address latch strobe separates low address from data on Port 0.
// - Fetch-force high and PC below 32 KB keeps ROM access off bus.
// - SRAM enable clear after reset; above 03FFH always external.
module emb_bus #(
	parameter int unsigned XRAM_WORDS = emb_pkg::XRAM_DEPTH
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Configuration
	input wire logic onchip_xram_enable_in,
	input wire logic [3:0] stretch_mc_in,
	input wire logic wait_enable_in,
	input wire logic external_fetch_force_in,
	// Request side
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire emb_pkg::emb_kind_t req_kind_in,
	input wire logic [15:0] req_addr_in,
	input wire logic [7:0] req_wdata_in,
	// Answer side
	output logic rsp_valid_out,
	input wire logic rsp_ready_in,
	output logic [7:0] rsp_data_out,
	output logic rsp_internal_out,
	// Port 0
	input wire logic [7:0] p0_in,
	output logic [7:0] p0_out,
	output logic [7:0] p0_oe_n_out,
	input wire logic [7:0] p0_gpio_in,
	// Port 2
	output logic [7:0] p2_out,
	output logic p2_strong_out,
	// Strobes
	output logic address_latch_strobe_out,
	output logic program_store_strobe_n_out,
	output logic write_strobe_n_out,
	output logic read_strobe_n_out,
	// Wait pin P4.0
	input wire logic p40_in,
	output logic p40_out,
	output logic p40_oe_n_out,
	input wire logic p40_gpio_in
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		emb_pkg::emb_state_t st;
		emb_pkg::emb_kind_t kind;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic [1:0] clk_cnt;
		logic [3:0] mc_cnt;
		logic [3:0] mc_len;
		logic ext;
		logic ale;
		logic program_store_strobe_n;
		logic wr_n;
		logic rd_n;
		logic [7:0] p0;
		logic p0_drive;
		logic [7:0] p2;
		logic p2_drive;
		logic [7:0] cap;
		logic [1:0] cnt;
		logic [7:0] b0_d;
		logic b0_i;
		logic [7:0] b1_d;
		logic b1_i;
		logic rd_pend;
	} emb_reg_t;

	emb_reg_t r;
	emb_reg_t next_r;
	logic [7:0] xram [XRAM_WORDS];
	logic [7:0] xram_q;
	logic xram_hit;
	logic bus_owned;

	function automatic logic [3:0] clamp_len(input logic [3:0] v);
		if (v < emb_pkg::STRETCH_MIN) begin
			return emb_pkg::STRETCH_MIN;
		end else if (v > emb_pkg::STRETCH_MAX) begin
			return emb_pkg::STRETCH_MAX;
		end
		return v;
	endfunction : clamp_len

	// ----------------------------------------
	// On-chip data SRAM
	// ----------------------------------------
	// SRAM write and read
	always_ff @(posedge sys_clk_in) begin
		if (r.st == emb_pkg::EMB_DONE && !r.ext &&
			r.kind == emb_pkg::EMB_DWRITE) begin
			xram[r.addr[9:0]] <= r.wdata;
		end
		xram_q <= xram[r.addr[9:0]];
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign req_ready_out = (r.st == emb_pkg::EMB_IDLE) && (r.cnt != 2'h2);
	assign rsp_valid_out = (r.cnt != 2'h0);
	assign rsp_data_out = r.b0_d;
	assign rsp_internal_out = r.b0_i;
	assign bus_owned = r.ext && (r.st != emb_pkg::EMB_IDLE);
	assign p0_out = r.p0_drive ? r.p0 : p0_gpio_in;
	// Open drain outside accesses
	assign p0_oe_n_out = r.p0_drive ? 8'h00 :
		(bus_owned ? 8'hff : p0_gpio_in);
	assign p2_out = r.p2;
	assign p2_strong_out = r.p2_drive;
	assign address_latch_strobe_out = r.ale;
	assign program_store_strobe_n_out = r.program_store_strobe_n;
	assign write_strobe_n_out = r.wr_n;
	assign read_strobe_n_out = r.rd_n;
	assign p40_out = p40_gpio_in;
	assign p40_oe_n_out = wait_enable_in | p40_gpio_in;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic data_move;
		logic pop;
		logic push;
		logic [7:0] pdata;
		logic pint;
		data_move = 1'b0;
		pop = rsp_valid_out && rsp_ready_in;
		push = 1'b0;
		pdata = 8'h00;
		pint = 1'b0;
		next_r = r;
		// Hit only when enabled and low
		xram_hit = onchip_xram_enable_in && req_addr_in <= emb_pkg::XRAM_TOP;
		next_r.clk_cnt = r.clk_cnt + 2'h1;
		case (r.st)
			emb_pkg::EMB_IDLE: begin
				next_r.clk_cnt = 2'h0;
				next_r.mc_cnt = 4'h0;
				if (req_valid_in && req_ready_out) begin
					data_move = req_kind_in == emb_pkg::EMB_DREAD ||
						req_kind_in == emb_pkg::EMB_DWRITE;
					next_r.kind = req_kind_in;
					next_r.addr = req_addr_in;
					next_r.wdata = req_wdata_in;
					next_r.mc_len = data_move ? clamp_len(stretch_mc_in) : 4'h1;
					if (data_move) begin
						next_r.ext = !xram_hit;
					end else begin
						next_r.ext = !(external_fetch_force_in &&
							req_addr_in <= emb_pkg::ROM_TOP);
					end
					next_r.st = emb_pkg::EMB_ADDR;
					if (next_r.ext) begin
						next_r.ale = 1'b1;
						next_r.p0 = req_addr_in[7:0];
						next_r.p0_drive = 1'b1;
						next_r.p2 = req_addr_in[15:8];
						next_r.p2_drive = 1'b1;
					end
				end
			end
			emb_pkg::EMB_ADDR: begin
				if (r.clk_cnt == 2'(emb_pkg::CLK_PER_MC / 2 - 1)) begin
					next_r.ale = 1'b0;
					next_r.st = emb_pkg::EMB_STROBE;
					if (r.ext) begin
						case (r.kind)
							emb_pkg::EMB_FETCH, emb_pkg::EMB_TABLE: begin
								next_r.program_store_strobe_n = 1'b0;
								next_r.p0_drive = 1'b0;
							end
							emb_pkg::EMB_DREAD: begin
								next_r.rd_n = 1'b0;
								next_r.p0_drive = 1'b0;
							end
							default: begin
								next_r.wr_n = 1'b0;
								next_r.p0 = r.wdata;
							end
						endcase
					end
				end
			end
			emb_pkg::EMB_STROBE: begin
				if (r.clk_cnt == 2'(emb_pkg::CLK_PER_MC - 1) &&
					r.mc_cnt != 4'hf) begin
					next_r.mc_cnt = r.mc_cnt + 4'h1;
				end
				if (r.clk_cnt == 2'(emb_pkg::CLK_PER_MC - 1) &&
					{1'b0, r.mc_cnt} + 5'h01 >= {1'b0, r.mc_len} &&
					!(wait_enable_in && r.ext && p40_in)) begin
					next_r.cap = p0_in;
					next_r.program_store_strobe_n = 1'b1;
					next_r.rd_n = 1'b1;
					next_r.wr_n = 1'b1;
					next_r.p0_drive = 1'b0;
					next_r.p2_drive = 1'b0;
					next_r.st = emb_pkg::EMB_DONE;
				end
			end
			default: begin
				next_r.st = emb_pkg::EMB_IDLE;
				next_r.rd_pend = 1'b1;
			end
		endcase
		if (r.rd_pend) begin
			next_r.rd_pend = 1'b0;
			push = 1'b1;
			pint = !r.ext;
			pdata = r.ext ? r.cap : (r.kind == emb_pkg::EMB_DWRITE ?
				r.wdata : xram_q);
		end
		// Two-entry answer buffer
		if (pop) begin
			next_r.b0_d = r.b1_d;
			next_r.b0_i = r.b1_i;
		end
		if (push) begin
			if (r.cnt == 2'h0 || (r.cnt == 2'h1 && pop)) begin
				next_r.b0_d = pdata;
				next_r.b0_i = pint;
			end else begin
				next_r.b1_d = pdata;
				next_r.b1_i = pint;
			end
		end
		next_r.cnt = r.cnt + 2'(push) - 2'(pop);
		if (sys_rst_in) begin
			next_r = '0;
			next_r.st = emb_pkg::EMB_IDLE;
			next_r.program_store_strobe_n = 1'b1;
			next_r.wr_n = 1'b1;
			next_r.rd_n = 1'b1;
			next_r.mc_len = emb_pkg::STRETCH_RST;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		r <= next_r;
	end
endmodule : emb_bus
